// file: inc/tsec_map.svh
// register offsets, reset values and field layout of the event controller
`ifndef TSEC_MAP_SVH
`define TSEC_MAP_SVH
`define TSEC_OFF_EVENT_LATCH    12'h000
`define TSEC_OFF_EVENT_MASK     12'h004
`define TSEC_OFF_EVENT_PENDING  12'h008
`define TSEC_OFF_GLOBAL_CTRL    12'h00C
`define TSEC_OFF_PERIPH_MASK    12'h010
`define TSEC_OFF_PERIPH_STATUS  12'h014
`define TSEC_OFF_PERIPH_WAKE    12'h018
`define TSEC_OFF_ASSIGN0        12'h020
`define TSEC_ASSIGN_REGS        4
`define TSEC_NUM_EVENTS         16
`define TSEC_NUM_SOURCES        32
`define TSEC_FIRST_GENERAL      7
`define TSEC_NUM_GENERAL        9
`define TSEC_RST_EVENT_MASK     16'h0000
`define TSEC_RST_PERIPH_MASK    32'h0000_0000
`define TSEC_RST_PERIPH_WAKE    32'h0000_0000
`define TSEC_UNASSIGNED         4'hF
// default assignment: 4-bit field per source, value = level - 7
`define TSEC_RST_ASSIGN0        32'h1111_00F0
`define TSEC_RST_ASSIGN1        32'h4433_3322
`define TSEC_RST_ASSIGN2        32'hFFF6_6554
`define TSEC_RST_ASSIGN3        32'hFFF8_7FFF
`endif

// file: inc/tsec_pkg.sv
// types of the two-stage event controller
package tsec_pkg;
   typedef logic [15:0] tsec_ev_t;
   typedef logic [31:0] tsec_src_t;
   typedef struct packed {
      tsec_ev_t    latch_r;
      tsec_ev_t    mask_r;
      tsec_ev_t    pending_r;
      logic        gen_en_r;
      tsec_src_t   pmask_r;
      tsec_src_t   pwake_r;
      logic [127:0] assign_r;
      logic [8:0]  req_s1_r;
      logic [8:0]  req_s2_r;
      logic [8:0]  req_d_r;
      logic [31:0] src_s1_r;
      logic [31:0] src_s2_r;
      logic        dph_r;
      logic        dwr_r;
      logic [11:0] daddr_r;
      logic [31:0] hrdata_r;
   } tsec_state_s;
endpackage

// file: rtl/tsec_ctrl.sv
// two-stage event controller with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tsec_map.svh"
module tsec_ctrl
   import tsec_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [6:0]  core_event_in,
   input  wire logic [31:0] periph_irq,
   input  wire logic        global_enable_instruction,
   input  wire logic        global_disable_instruction,
   input  wire logic        core_accept,
   input  wire logic [3:0]  core_accept_class,
   input  wire logic        core_return,
   input  wire logic [3:0]  core_return_class,
   output logic             event_request,
   output logic [3:0]       event_class,
   output logic             wakeup
);
   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   tsec_state_s st_r;
   tsec_state_s st_nxt;
   logic [8:0]  level_req;
   logic [8:0]  req_rise;
   tsec_ev_t    raw_ev;
   tsec_ev_t    servable;
   logic        found;
   logic [3:0]  win;
   logic [3:0]  fld;

   // a source joins a level only if unmasked and its field is in range
   always_comb begin
      level_req = '0;
      fld       = 4'h0;
      for (int s = 0; s < `TSEC_NUM_SOURCES; s++) begin
         fld = st_r.assign_r[s*4 +: 4];
         if (st_r.src_s2_r[s] && st_r.pmask_r[s] && fld < 4'(`TSEC_NUM_GENERAL)) begin
            level_req[fld] = 1'b1;
         end
      end
   end

   assign req_rise = st_r.req_s2_r & ~st_r.req_d_r;

   // dedicated events are levels; general ones enter through latched edges
   assign raw_ev = {9'h000, core_event_in} | {req_rise, 7'h00};

   // nothing new is taken while a more urgent class is active (nesting)
   always_comb begin
      servable = st_r.latch_r & st_r.mask_r;
      if (!st_r.gen_en_r) begin
         servable[15:7] = 9'h000;
      end
      found = 1'b0;
      win   = 4'h0;
      for (int c = 0; c < `TSEC_NUM_EVENTS; c++) begin
         if (!found && servable[c]) begin
            found = 1'b1;
            win   = 4'(c);
         end
      end
      if (found) begin
         for (int c = 0; c < `TSEC_NUM_EVENTS; c++) begin
            if (c <= int'(win) && st_r.pending_r[c]) begin
               found = 1'b0;
            end
         end
      end
   end

   assign event_request = found;
   assign event_class   = win;
   assign wakeup        = |(st_r.src_s2_r & st_r.pwake_r);
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = st_r.hrdata_r;

   always_comb begin
      st_nxt = st_r;
      st_nxt.src_s1_r = periph_irq;
      st_nxt.src_s2_r = st_r.src_s1_r;
      st_nxt.req_s1_r = level_req;
      st_nxt.req_s2_r = st_r.req_s1_r;
      st_nxt.req_d_r  = st_r.req_s2_r;
      //--------------------------------------------------------------
      // core stage
      //--------------------------------------------------------------
      if (global_enable_instruction) begin
         st_nxt.gen_en_r = 1'b1;
      end else if (global_disable_instruction) begin
         st_nxt.gen_en_r = 1'b0;
      end
      if (core_return) begin
         st_nxt.pending_r[core_return_class] = 1'b0;
      end
      if (core_accept) begin
         st_nxt.pending_r[core_accept_class] = 1'b1;
         st_nxt.latch_r[core_accept_class]   = 1'b0;
      end
      // a new edge in the acceptance cycle stays latched for later
      st_nxt.latch_r = st_nxt.latch_r | raw_ev;
      //--------------------------------------------------------------
      // bus slave, zero wait states
      //--------------------------------------------------------------
      if (st_r.dph_r && st_r.dwr_r) begin
         case (st_r.daddr_r)
            `TSEC_OFF_EVENT_MASK:  st_nxt.mask_r  = hwdata[15:0];
            `TSEC_OFF_GLOBAL_CTRL: st_nxt.gen_en_r = hwdata[0];
            `TSEC_OFF_PERIPH_MASK: st_nxt.pmask_r = hwdata;
            `TSEC_OFF_PERIPH_WAKE: st_nxt.pwake_r = hwdata;
            `TSEC_OFF_ASSIGN0:       st_nxt.assign_r[31:0]   = hwdata;
            `TSEC_OFF_ASSIGN0 + 12'h004: st_nxt.assign_r[63:32]  = hwdata;
            `TSEC_OFF_ASSIGN0 + 12'h008: st_nxt.assign_r[95:64]  = hwdata;
            `TSEC_OFF_ASSIGN0 + 12'h00C: st_nxt.assign_r[127:96] = hwdata;
            default: ; // unmapped or read-only: write dropped, still OKAY
         endcase
      end
      st_nxt.dph_r = hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
         st_nxt.dwr_r   = hwrite;
         st_nxt.daddr_r = haddr[11:0];
         case (haddr[11:0])
            `TSEC_OFF_EVENT_LATCH:   st_nxt.hrdata_r = {16'h0000, st_r.latch_r};
            `TSEC_OFF_EVENT_MASK:    st_nxt.hrdata_r = {16'h0000, st_r.mask_r};
            `TSEC_OFF_EVENT_PENDING: st_nxt.hrdata_r = {16'h0000, st_r.pending_r};
            `TSEC_OFF_GLOBAL_CTRL:   st_nxt.hrdata_r = {31'h0000_0000, st_r.gen_en_r};
            `TSEC_OFF_PERIPH_MASK:   st_nxt.hrdata_r = st_r.pmask_r;
            `TSEC_OFF_PERIPH_STATUS: st_nxt.hrdata_r = st_r.src_s2_r;
            `TSEC_OFF_PERIPH_WAKE:   st_nxt.hrdata_r = st_r.pwake_r;
            `TSEC_OFF_ASSIGN0:           st_nxt.hrdata_r = st_r.assign_r[31:0];
            `TSEC_OFF_ASSIGN0 + 12'h004: st_nxt.hrdata_r = st_r.assign_r[63:32];
            `TSEC_OFF_ASSIGN0 + 12'h008: st_nxt.hrdata_r = st_r.assign_r[95:64];
            `TSEC_OFF_ASSIGN0 + 12'h00C: st_nxt.hrdata_r = st_r.assign_r[127:96];
            default: st_nxt.hrdata_r = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r           <= '0;
         st_r.mask_r    <= `TSEC_RST_EVENT_MASK;
         st_r.pmask_r   <= `TSEC_RST_PERIPH_MASK;
         st_r.pwake_r   <= `TSEC_RST_PERIPH_WAKE;
         st_r.assign_r  <= {`TSEC_RST_ASSIGN3, `TSEC_RST_ASSIGN2,
                            `TSEC_RST_ASSIGN1, `TSEC_RST_ASSIGN0};
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   property p_latch_on_rise;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && req_rise[0] |=> st_r.latch_r[7];
   endproperty
   a_latch_on_rise: assert property (p_latch_on_rise) else $error("edge did not latch");

   property p_masked_no_req;
      @(posedge hclk) disable iff (!hresetn)
      event_request |-> st_r.mask_r[event_class];
   endproperty
   a_masked_no_req: assert property (p_masked_no_req) else $error("masked event requested");

   property p_gen_disabled;
      @(posedge hclk) disable iff (!hresetn)
      event_request && !st_r.gen_en_r |-> event_class < 4'h7;
   endproperty
   a_gen_disabled: assert property (p_gen_disabled) else $error("general level while disabled");

   property p_accept_sets_pending;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && core_accept && !(core_return && core_return_class == core_accept_class)
      |=> st_r.pending_r[$past(core_accept_class)];
   endproperty
   a_accept_sets_pending: assert property (p_accept_sets_pending) else $error("pending not set");

   property p_status_tracks;
      @(posedge hclk) disable iff (!hresetn)
      clk_en ##1 clk_en |=> st_r.src_s2_r == $past(periph_irq, 2);
   endproperty
   a_status_tracks: assert property (p_status_tracks) else $error("status lags wrong");

   property p_wake;
      @(posedge hclk) disable iff (!hresetn)
      clk_en ##1 clk_en |=> wakeup == |($past(periph_irq, 2) & st_r.pwake_r);
   endproperty
   a_wake: assert property (p_wake) else $error("wake from disabled source");

   property p_pending_latency;
      @(posedge hclk) disable iff (!hresetn)
      $rose(st_r.latch_r[7]) |-> !st_r.pending_r[7] || $past(st_r.pending_r[7]);
   endproperty
   a_pending_latency: assert property (p_pending_latency) else $error("pending too early");

   property p_priority;
      @(posedge hclk) disable iff (!hresetn)
      event_request |-> ((servable & ((16'h0001 << event_class) - 16'h0001)) == 16'h0000);
   endproperty
   a_priority: assert property (p_priority) else $error("lower class chosen");

   property p_mask_write;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_EVENT_MASK
      |=> st_r.mask_r == $past(hwdata[15:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("event mask write lost");

   property p_pmask_write;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_PERIPH_MASK
      |=> st_r.pmask_r == $past(hwdata);
   endproperty
   a_pmask_write: assert property (p_pmask_write) else $error("peripheral mask write lost");

   property p_pwake_write;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_PERIPH_WAKE
      |=> st_r.pwake_r == $past(hwdata);
   endproperty
   a_pwake_write: assert property (p_pwake_write) else $error("wake enable write lost");

   property p_assign_write;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_ASSIGN0
      |=> st_r.assign_r[31:0] == $past(hwdata);
   endproperty
   a_assign_write: assert property (p_assign_write) else $error("assignment write lost");

   property p_read_latch;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `TSEC_OFF_EVENT_LATCH
      |=> hrdata == {16'h0000, $past(st_r.latch_r)};
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

   property p_read_pending;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `TSEC_OFF_EVENT_PENDING
      |=> hrdata == {16'h0000, $past(st_r.pending_r)};
   endproperty
   a_read_pending: assert property (p_read_pending) else $error("pending read wrong");

   property p_read_status;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `TSEC_OFF_PERIPH_STATUS
      |=> hrdata == $past(st_r.src_s2_r);
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read wrong");

   property p_read_unmapped;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h0FC
      |=> hrdata == 32'h0000_0000;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

   property p_latch_clear;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && core_accept && !raw_ev[core_accept_class] |=> !st_r.latch_r[$past(core_accept_class)];
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch kept after accept");

   property p_latch_hold;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && !core_accept |=> (st_r.latch_r & $past(st_r.latch_r)) == $past(st_r.latch_r);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch lost without accept");

   property p_return_clears;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && core_return && !(core_accept && core_accept_class == core_return_class)
      |=> !st_r.pending_r[$past(core_return_class)];
   endproperty
   a_return_clears: assert property (p_return_clears) else $error("pending kept after return");

   property p_gen_enable;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && global_enable_instruction && !(st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_GLOBAL_CTRL)
      |=> st_r.gen_en_r;
   endproperty
   a_gen_enable: assert property (p_gen_enable) else $error("global enable ignored");

   property p_gen_disable;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && global_disable_instruction && !global_enable_instruction &&
      !(st_r.dph_r && st_r.dwr_r && st_r.daddr_r == `TSEC_OFF_GLOBAL_CTRL) |=> !st_r.gen_en_r;
   endproperty
   a_gen_disable: assert property (p_gen_disable) else $error("global disable ignored");

   property p_level_route;
      @(posedge hclk) disable iff (!hresetn)
      st_r.src_s2_r[0] && st_r.pmask_r[0] && st_r.assign_r[3:0] == 4'h0 |-> level_req[0];
   endproperty
   a_level_route: assert property (p_level_route) else $error("source not routed");

   property p_pmask_zero;
      @(posedge hclk) disable iff (!hresetn)
      st_r.pmask_r == 32'h0000_0000 |-> level_req == 9'h000;
   endproperty
   a_pmask_zero: assert property (p_pmask_zero) else $error("masked source reached level");

   property p_req_latched;
      @(posedge hclk) disable iff (!hresetn)
      event_request |-> st_r.latch_r[event_class];
   endproperty
   a_req_latched: assert property (p_req_latched) else $error("request without latch");

   property p_req_not_active;
      @(posedge hclk) disable iff (!hresetn)
      event_request |-> !st_r.pending_r[event_class];
   endproperty
   a_req_not_active: assert property (p_req_not_active) else $error("active class requested");

   property p_edge_two;
      @(posedge hclk) disable iff (!hresetn)
      req_rise[0] && $past(clk_en) |-> $past(st_r.req_s1_r[0]);
   endproperty
   a_edge_two: assert property (p_edge_two) else $error("edge seen without input");

   property p_dph_taken;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && hsel && hready && htrans[1] |=> st_r.dph_r;
   endproperty
   a_dph_taken: assert property (p_dph_taken) else $error("address phase missed");

   property p_wake_none;
      @(posedge hclk) disable iff (!hresetn)
      st_r.pwake_r == 32'h0000_0000 |-> !wakeup;
   endproperty
   a_wake_none: assert property (p_wake_none) else $error("wake with none enabled");

   property p_freeze;
      @(posedge hclk) disable iff (!hresetn)
      !clk_en |=> st_r == $past(st_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   // the core can only accept what it saw requested, so three quiet cycles follow an input edge
   property p_pending_min;
      @(posedge hclk) disable iff (!hresetn)
      $rose(st_r.req_s1_r[0]) && !st_r.latch_r[7] && !st_r.pending_r[7]
      |-> ##1 !st_r.pending_r[7] ##1 !st_r.pending_r[7] ##1 !st_r.pending_r[7];
   endproperty
   a_pending_min: assert property (p_pending_min) else $error("pending within three cycles");
endmodule
`default_nettype wire

// file: tb/tsec_core_model.sv
// core pipeline model: takes requested events, returns from them later
`timescale 1ns/1ps
`default_nettype none
module tsec_core_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       hold,
   input  wire logic       event_request,
   input  wire logic [3:0] event_class,
   output logic            core_accept,
   output logic [3:0]      core_accept_class,
   output logic            core_return,
   output logic [3:0]      core_return_class
);
   logic [4:0] cnt;
   logic [3:0] cls;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt               <= 5'h00;
         cls               <= 4'h0;
         core_accept       <= 1'b0;
         core_return       <= 1'b0;
         core_accept_class <= 4'h0;
         core_return_class <= 4'h0;
      end else begin
         core_accept       <= 1'b0;
         core_return       <= (cnt == 5'h01);
         // qualifiers toggle outside a pulse so a stale class never passes
         core_accept_class <= ~core_accept_class;
         core_return_class <= (cnt == 5'h01) ? cls : ~core_return_class;
         if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end else if (event_request && !hold) begin
            // one handler at a time keeps the nesting simple
            core_accept       <= 1'b1;
            core_accept_class <= event_class;
            cls               <= event_class;
            cnt               <= 5'h18;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/two_stage_event_controller_tb_top.sv
// self-checking bench of the two-stage event controller
`timescale 1ns/1ps
`default_nettype none
`include "tsec_map.svh"
module two_stage_event_controller_tb_top import tsec_pkg::*; ;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold = 1'b1, rd_dph = 1'b0;
   logic        gen_on = 1'b0, gen_off = 1'b0, hreadyout, hresp, ev_req, acc, ret, wake;
   logic [1:0]  htrans = 2'b00;
   logic [6:0]  cev = 7'h00;
   logic [3:0]  ev_cls, acc_cls, ret_cls;
   logic [31:0] haddr = '0, hwdata = '0, irq = '0, hrdata, v, w;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0, total_checks = 0, seed = 32'h4a49;
   int          src[9] = '{0, 4, 8, 10, 14, 17, 19, 27, 28};
   initial forever #2 hclk = ~hclk;
   tsec_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .core_event_in(cev), .periph_irq(irq), .global_enable_instruction(gen_on),
      .global_disable_instruction(gen_off), .core_accept(acc), .core_accept_class(acc_cls), .core_return(ret),
      .core_return_class(ret_cls), .event_request(ev_req), .event_class(ev_cls), .wakeup(wake));
   tsec_core_model CORE (.hclk(hclk), .hresetn(hresetn), .hold(hold), .event_request(ev_req),
      .event_class(ev_cls), .core_accept(acc), .core_accept_class(acc_cls), .core_return(ret),
      .core_return_class(ret_cls));
   task automatic chk(input string nm, input logic [31:0] e, s);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr_en;
      haddr <= {20'h0_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_dph <= !wr_en;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dph <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, $random(seed));
   endtask
   always @(posedge hclk) begin
      if (rd_dph === 1'b1 && hreadyout === 1'b1) begin
         chk("hrdata", exp_q.pop_front(), hrdata);
         chk("hresp", '0, {31'h0, hresp});
      end
   end
   // pulse one source, expect a request or none, then let the core take it
   task automatic fire(input int s, input logic [3:0] lv, input logic want);
      int n;
      n = 0;
      irq[s] <= 1'b1;
      while (ev_req !== 1'b1 && n++ < 12) @(negedge hclk);
      chk("event_request", {31'h0, want}, {31'h0, ev_req});
      if (want) begin
         chk("event_class", {28'h0, lv}, {28'h0, ev_cls});
         rd(`TSEC_OFF_EVENT_LATCH, 32'h1 << lv);
         hold <= 1'b0;
         @(posedge hclk);
         rd(`TSEC_OFF_EVENT_PENDING, 32'h1 << lv);
         rd(`TSEC_OFF_EVENT_LATCH, '0);
      end
      @(posedge hclk);
      irq[s] <= 1'b0;
      hold <= 1'b1;
      repeat (30) @(posedge hclk);
   endtask
   task automatic report_and_stop;
      if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`TSEC_OFF_EVENT_MASK, '0);
      rd(`TSEC_OFF_PERIPH_MASK, '0);
      rd(`TSEC_OFF_ASSIGN0, `TSEC_RST_ASSIGN0);
      rd(`TSEC_OFF_ASSIGN0 + 12'h004, `TSEC_RST_ASSIGN1);
      rd(`TSEC_OFF_ASSIGN0 + 12'h008, `TSEC_RST_ASSIGN2);
      rd(`TSEC_OFF_ASSIGN0 + 12'h00C, `TSEC_RST_ASSIGN3);
      rd(12'h0FC, '0);
      v = $random(seed);
      w = $random(seed);
      wr(`TSEC_OFF_EVENT_MASK, v);
      rd(`TSEC_OFF_EVENT_MASK, {16'h0000, v[15:0]});
      wr(`TSEC_OFF_PERIPH_MASK, w);
      rd(`TSEC_OFF_PERIPH_MASK, w);
      wr(`TSEC_OFF_PERIPH_WAKE, v);
      rd(`TSEC_OFF_PERIPH_WAKE, v);
      // sources masked off so the random pattern latches nothing
      wr(`TSEC_OFF_PERIPH_MASK, '0);
      irq <= w;
      repeat (4) @(posedge hclk);
      wr(`TSEC_OFF_PERIPH_STATUS, '1);
      rd(`TSEC_OFF_PERIPH_STATUS, w);
      @(negedge hclk);
      chk("wakeup", {31'h0, |(v & w)}, {31'h0, wake});
      @(posedge hclk);
      irq <= '0;
      wr(`TSEC_OFF_PERIPH_MASK, '1);
      wr(`TSEC_OFF_EVENT_MASK, 32'h0000_FFFF);
      gen_on <= 1'b1;
      @(posedge hclk);
      gen_on <= 1'b0;
      for (int i = 0; i < 9; i++) fire(src[i], 4'(7 + i), 1'b1);
      wr(`TSEC_OFF_ASSIGN0, 32'h1111_00F3);
      fire(0, 4'hA, 1'b1);
      wr(`TSEC_OFF_ASSIGN0, 32'h1111_00F9);
      fire(0, 4'h0, 1'b0);
      wr(`TSEC_OFF_ASSIGN0, `TSEC_RST_ASSIGN0);
      wr(`TSEC_OFF_PERIPH_MASK, 32'hFFFF_FFFE);
      fire(0, 4'h0, 1'b0);
      wr(`TSEC_OFF_PERIPH_MASK, '1);
      wr(`TSEC_OFF_EVENT_MASK, 32'h0000_FF7F);
      fire(0, 4'h0, 1'b0);
      rd(`TSEC_OFF_EVENT_LATCH, 32'h0000_0080);
      gen_off <= 1'b1;
      @(posedge hclk);
      gen_off <= 1'b0;
      wr(`TSEC_OFF_EVENT_MASK, 32'h0000_FFFF);
      @(negedge hclk);
      chk("event_request", '0, {31'h0, ev_req});
      // register path re-enables level 7, then a dedicated class must overtake it
      wr(`TSEC_OFF_GLOBAL_CTRL, 32'h0000_0001);
      rd(`TSEC_OFF_GLOBAL_CTRL, 32'h0000_0001);
      cev <= 7'h40;
      @(negedge hclk);
      chk("event_class", 32'h0000_0007, {28'h0, ev_cls});
      @(negedge hclk);
      chk("event_class", 32'h0000_0006, {28'h0, ev_cls});
      @(posedge hclk);
      report_and_stop();
   end
endmodule
`default_nettype wire
